// [design/ewc_pkg.sv]
// Package: register map, field layout and types for the external bus wait-state control
package ewc_pkg;
   // Register byte offsets (Wishbone, one aligned word each)
   localparam logic [3:0]  WAIT_CTRL_OFS      = 4'h0;
   localparam logic [3:0]  REQ_ADDR_OFS       = 4'h4;
   localparam logic [3:0]  REQ_DATA_OFS       = 4'h8;
   localparam logic [3:0]  REQ_CMD_OFS        = 4'hc;
   // Wait-state control fields
   localparam int LOW_WAIT_LSB  = 0;
   localparam int UP_WAIT_LSB   = 3;
   localparam int IO_WAIT_LSB   = 9;
   localparam int PSEL_BIT      = 0;
   localparam int WAIT_W        = 3;
   // Reset: full wait states everywhere, as slow memories are safe
   localparam logic [15:0] WAIT_CTRL_RST      = 16'h0e3f;
   localparam logic [15:0] WAIT_CTRL_MASK     = 16'h0e3f;
   localparam logic [15:0] WAIT_CTRL_MASK_RED = 16'h0001;
   // Reduced variant: wait count applied to program reads when the select bit is set
   localparam logic [2:0]  RED_WAIT_COUNT     = 3'h1;
   // Command register fields
   localparam int CMD_GO_BIT    = 0;
   localparam int CMD_WR_BIT    = 1;
   localparam int CMD_SP_LSB    = 2;
   localparam int CMD_BUSY_BIT  = 8;
   // Program-space upper-half address bit
   localparam int UPPER_BIT     = 15;

   typedef enum logic [1:0] {
      EWC_SP_PROG = 2'h0,
      EWC_SP_DATA = 2'h1,
      EWC_SP_IO   = 2'h2
   } ewc_space_e;

   typedef enum logic [2:0] {
      EWC_IDLE   = 3'b001,
      EWC_WAIT   = 3'b010,
      EWC_READY  = 3'b100
   } ewc_state_e;

   typedef struct packed {
      logic        prog_sel;
      logic        data_sel;
      logic        io_sel;
      logic        rd_sel;
      logic        rd_wr;
      logic        strobe;
   } ewc_ctl_s;
endpackage : ewc_pkg

// [design/ewc_top.sv]
// External bus interface with programmable and ready-driven wait states
// Notes on behaviour
// - Lower program half wait count bits 2..0
// - Upper program half wait count bits 5..3
// - Reduced variant: bit 0 selects program read wait
// - Ready low: wait a cycle, resample
// - Stall access until ready returns high
// - Program select asserted on program accesses
// - Read select usable as output enable
// - Direction output marks read or write
// - I/O wait count bits 11..9
// - I/O select asserted on I/O accesses
// - Strobe asserted during every external access
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ewc_top #(
   parameter bit REDUCED = 1'b0
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [15:0] ext_addr_o,
   output logic      [15:0] ext_dout_o,
   output logic             ext_dout_oe_o,
   input  wire logic [15:0] ext_din_i,
   input  wire logic        ext_ready_i,
   output var ewc_pkg::ewc_ctl_s ext_ctl_o
);
   import ewc_pkg::*;

   ewc_state_e  state_reg,    state_next;
   logic [15:0] wctl_reg,     wctl_next;
   logic [15:0] addr_reg,     addr_next;
   logic [15:0] wdat_reg,     wdat_next;
   logic [15:0] rdat_reg,     rdat_next;
   logic        wr_reg,       wr_next;
   ewc_space_e  sp_reg,       sp_next;
   logic [2:0]  cnt_reg,      cnt_next;
   logic        ack_reg,      ack_next;
   logic [31:0] dat_reg,      dat_next;
   logic        busy;
   logic        wb_req;
   logic        go;

   // Wait count for the addressed space
   function automatic logic [2:0] wait_for(input logic [15:0] wctl, input ewc_space_e sp,
                                           input logic [15:0] adr, input logic wr, input bit red);
      logic [2:0] w;
      w = '0;
      if (sp == EWC_SP_PROG)
      begin
         if (red)
            w = (wctl[PSEL_BIT] && !wr) ? RED_WAIT_COUNT : 3'h0;
         else if (adr[UPPER_BIT])
            w = wctl[UP_WAIT_LSB +: WAIT_W];
         else
            w = wctl[LOW_WAIT_LSB +: WAIT_W];
      end
      else if (sp == EWC_SP_IO && !red)
         w = wctl[IO_WAIT_LSB +: WAIT_W];
      return w;
   endfunction : wait_for

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0])
         r[7:0] = d[7:0];
      if (sel[1])
         r[15:8] = d[15:8];
      return r;
   endfunction : merge16

   assign busy   = (state_reg != EWC_IDLE);
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign go     = wb_req && wb_we_i && (wb_adr_i == REQ_CMD_OFS) && wb_sel_i[0] && wb_dat_i[CMD_GO_BIT] && !busy;

   always_comb
   begin
      ack_next  = wb_req;
      dat_next  = '0;
      wctl_next = wctl_reg;
      addr_next = addr_reg;
      wdat_next = wdat_reg;
      if (wb_req && wb_we_i)
      begin
         unique case (wb_adr_i)
            WAIT_CTRL_OFS:
               wctl_next = merge16(wctl_reg, wb_dat_i, wb_sel_i) & (REDUCED ? WAIT_CTRL_MASK_RED : WAIT_CTRL_MASK);
            REQ_ADDR_OFS:
               addr_next = busy ? addr_reg : merge16(addr_reg, wb_dat_i, wb_sel_i);
            REQ_DATA_OFS:
               wdat_next = busy ? wdat_reg : merge16(wdat_reg, wb_dat_i, wb_sel_i);
            default:
               ;
         endcase
      end
      else if (wb_req)
      begin
         unique case (wb_adr_i)
            WAIT_CTRL_OFS: dat_next = {16'h0000, wctl_reg};
            REQ_ADDR_OFS:  dat_next = {16'h0000, addr_reg};
            REQ_DATA_OFS:  dat_next = {16'h0000, rdat_reg};
            REQ_CMD_OFS:   dat_next = {23'h000000, busy, 4'h0, sp_reg, wr_reg, 1'b0};
            default:       dat_next = '0;
         endcase
      end
   end

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      wr_next    = wr_reg;
      sp_next    = sp_reg;
      rdat_next  = rdat_reg;
      unique case (state_reg)
         EWC_IDLE:
         begin
            if (go)
            begin
               wr_next    = wb_dat_i[CMD_WR_BIT];
               sp_next    = ewc_space_e'(wb_dat_i[CMD_SP_LSB +: 2]);
               cnt_next   = wait_for(wctl_reg, ewc_space_e'(wb_dat_i[CMD_SP_LSB +: 2]),
                                     addr_reg, wb_dat_i[CMD_WR_BIT], REDUCED);
               state_next = EWC_WAIT;
            end
         end
         EWC_WAIT:
         begin
            if (cnt_reg != 3'h0)
               cnt_next = cnt_reg - 3'h1;
            else
               state_next = EWC_READY;
         end
         EWC_READY:
         begin
            if (ext_ready_i)
            begin
               if (!wr_reg)
                  rdat_next = ext_din_i;
               state_next = EWC_IDLE;
            end
         end
         default:
            state_next = EWC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= EWC_IDLE;
         wctl_reg  <= REDUCED ? WAIT_CTRL_MASK_RED : WAIT_CTRL_RST;
         addr_reg  <= '0;
         wdat_reg  <= '0;
         rdat_reg  <= '0;
         wr_reg    <= 1'b0;
         sp_reg    <= EWC_SP_PROG;
         cnt_reg   <= '0;
         ack_reg   <= 1'b0;
         dat_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         wctl_reg  <= wctl_next;
         addr_reg  <= addr_next;
         wdat_reg  <= wdat_next;
         rdat_reg  <= rdat_next;
         wr_reg    <= wr_next;
         sp_reg    <= sp_next;
         cnt_reg   <= cnt_next;
         ack_reg   <= ack_next;
         dat_reg   <= dat_next;
      end
   end

   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = dat_reg;
   assign ext_addr_o    = addr_reg;
   assign ext_dout_o    = wdat_reg;
   // Data lines driven only during a write so the bus never fights memory
   assign ext_dout_oe_o = busy && wr_reg;

   always_comb
   begin
      ext_ctl_o.prog_sel = busy && (sp_reg == EWC_SP_PROG);
      ext_ctl_o.data_sel = busy && (sp_reg == EWC_SP_DATA);
      ext_ctl_o.io_sel   = busy && (sp_reg == EWC_SP_IO);
      ext_ctl_o.rd_sel   = busy && !wr_reg;
      ext_ctl_o.rd_wr    = busy ? !wr_reg : 1'b1;
      ext_ctl_o.strobe   = busy;
   end

   chk_strobe_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      ext_ctl_o.strobe == (state_reg != EWC_IDLE)) else $error("strobe mismatch");
   chk_ready_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_READY && !ext_ready_i) |=> state_reg == EWC_READY) else $error("ready stall lost");
   chk_ready_end: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_READY && ext_ready_i) |=> state_reg == EWC_IDLE) else $error("ready not honoured");
   chk_lower_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && !REDUCED && wb_dat_i[CMD_SP_LSB +: 2] == 2'h0 && !addr_reg[UPPER_BIT])
      |=> cnt_reg == $past(wctl_reg[2:0])) else $error("lower wait wrong");
   chk_upper_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && !REDUCED && wb_dat_i[CMD_SP_LSB +: 2] == 2'h0 && addr_reg[UPPER_BIT])
      |=> cnt_reg == $past(wctl_reg[5:3])) else $error("upper wait wrong");
   chk_io_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && !REDUCED && wb_dat_i[CMD_SP_LSB +: 2] == 2'h2)
      |=> cnt_reg == $past(wctl_reg[11:9])) else $error("io wait wrong");
   // zero wait reaches ready in one cycle
   chk_zero_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_WAIT && cnt_reg == 3'h0) |=> state_reg == EWC_READY) else $error("wait overrun");
   chk_read_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      ext_ctl_o.rd_sel |-> ext_ctl_o.rd_wr && ext_ctl_o.strobe) else $error("read select bad");
   // one space select at a time
   chk_one_space: assert property (@(posedge clk_i) disable iff (rst_i)
      busy |-> $onehot({ext_ctl_o.prog_sel, ext_ctl_o.data_sel, ext_ctl_o.io_sel})) else $error("space select bad");

   // go opens the access next cycle
   chk_go_starts: assert property (@(posedge clk_i) disable iff (rst_i)
      go |=> ext_ctl_o.strobe && state_reg == EWC_WAIT) else $error("access did not start");

   // wait count steps down by one
   chk_wait_count: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_WAIT && cnt_reg != 3'h0)
      |=> state_reg == EWC_WAIT && cnt_reg == $past(cnt_reg) - 3'h1) else $error("wait count step bad");

   // read word taken while ready is high in the ready state
   chk_read_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_READY && ext_ready_i && !wr_reg)
      |=> rdat_reg == $past(ext_din_i)) else $error("read data not captured");

   chk_prog_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && sp_reg == EWC_SP_PROG)
      |-> ext_ctl_o.prog_sel && !ext_ctl_o.io_sel) else $error("program select missing");

   chk_io_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && sp_reg == EWC_SP_IO)
      |-> ext_ctl_o.io_sel && !ext_ctl_o.prog_sel) else $error("io select missing");

   chk_write_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy && wr_reg)
      |-> !ext_ctl_o.rd_wr && !ext_ctl_o.rd_sel && ext_dout_oe_o) else $error("write direction bad");

   chk_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !busy |-> !ext_ctl_o.strobe && !ext_ctl_o.rd_sel && ext_ctl_o.rd_wr && !ext_dout_oe_o)
      else $error("idle bus not quiet");

   chk_ctl_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      busy |=> !busy || ($stable(ext_ctl_o.rd_sel) && $stable(ext_addr_o))) else $error("controls moved");

   // reduced program wait from select bit
   chk_red_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && REDUCED && wb_dat_i[CMD_SP_LSB +: 2] == 2'h0)
      |=> cnt_reg == (($past(wctl_reg[PSEL_BIT]) && !$past(wb_dat_i[CMD_WR_BIT])) ? RED_WAIT_COUNT : 3'h0))
      else $error("reduced wait wrong");

   // reduced variant has no other waits
   chk_red_other: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && REDUCED && wb_dat_i[CMD_SP_LSB +: 2] != 2'h0) |=> cnt_reg == 3'h0) else $error("reduced extra wait");

   chk_data_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      (go && wb_dat_i[CMD_SP_LSB +: 2] == 2'h1) |=> cnt_reg == 3'h0) else $error("data wait wrong");

   // ready is not honoured during counting
   chk_wait_no_end: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_WAIT) |=> state_reg != EWC_IDLE) else $error("wait ended early");

   chk_ready_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == EWC_READY && !ext_ready_i) |=> ext_ctl_o.strobe) else $error("strobe dropped on stall");
endmodule : ewc_top
`default_nettype wire

// [tb/ewc_mem_model.sv]
// External memory model with a programmable ready stall
`timescale 1ns/100ps
`default_nettype none
module ewc_mem_model
   import ewc_pkg::*;
(
   input  wire ewc_pkg::ewc_ctl_s ctl_i,
   input  wire logic              clk_i,
   input  wire logic [15:0]       addr_i,
   input  wire logic [15:0]       dout_i,
   input  wire logic [3:0]        stall_i,
   output logic      [15:0]       din_o,
   output logic                   ready_o
);
   logic [15:0] mem [256];
   logic [15:0] last_reg = 16'h5a5a;
   logic [3:0]  cnt_reg  = 4'h0;
   // ready low for the first stall cycles
   assign ready_o = !(ctl_i.strobe && cnt_reg < stall_i);
   // Idle bus toggles so a stale word never passes
   assign din_o = ctl_i.rd_sel ? mem[addr_i[7:0]] : ~last_reg;
   always @(posedge clk_i)
   begin
      last_reg <= din_o;
      cnt_reg  <= ctl_i.strobe ? cnt_reg + 4'h1 : 4'h0;
      if (ctl_i.strobe && !ctl_i.rd_wr && ready_o)
         mem[addr_i[7:0]] <= dout_i;
   end
endmodule : ewc_mem_model
`default_nettype wire

// [tb/ewc_top_tb.sv]
// Self-checking bench for the wait-state bus interface
`timescale 1ns/100ps
`default_nettype none
module ewc_top_tb;
   import ewc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [3:0]  adr   = 4'h0;
   logic [3:0]  stall = 4'h0;
   logic [31:0] wdat  = 32'h0000_0000;
   logic [31:0] rdat, dat_o;
   logic        ack, oe, ready, cap_oe;
   logic [15:0] ext_addr, ext_dout, din, cap_addr, cap_dout;
   ewc_ctl_s    ctl, cap;
   int          failures = 0;
   int          n_tests  = 0;
   int          run = 0;
   int          len = 0;
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   ewc_top #(.REDUCED(1'b0)) ewc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ext_addr_o(ext_addr), .ext_dout_o(ext_dout), .ext_dout_oe_o(oe), .ext_din_i(din),
      .ext_ready_i(ready), .ext_ctl_o(ctl));
   ewc_mem_model ewc_mem_model_i (.ctl_i(ctl), .clk_i(clk_i), .addr_i(ext_addr), .dout_i(ext_dout),
      .stall_i(stall), .din_o(din), .ready_o(ready));
   // Length of each strobe and what the bus showed during it
   always @(posedge clk_i)
   begin
      if (ctl.strobe === 1'b1)
      begin
         run      <= run + 1;
         cap      <= ctl;
         cap_oe   <= oe;
         cap_addr <= ext_addr;
         cap_dout <= ext_dout;
      end
      else if (run != 0)
      begin
         len <= run;
         run <= 0;
      end
   end
   task automatic close_out;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One classic cycle; idle cycle after so strobe never re-rises at once
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack !== 1'b1 && i < 50);
      rdat = dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
      if (i >= 50)
      begin
         failures++;
         close_out();
      end
   endtask : wb
   // Full external access; n below zero skips the length check
   task automatic acc(input logic [1:0] sp, input logic w, input logic [15:0] a, input logic [15:0] d,
                      input int n, input logic [3:0] l);
      int i;
      stall <= l;
      wb(1'b1, REQ_ADDR_OFS, {16'h0000, a});
      wb(1'b1, REQ_DATA_OFS, {16'h0000, d});
      len = 0;
      wb(1'b1, REQ_CMD_OFS, {28'h000_0000, sp, w, 1'b1});
      i = 0;
      do
      begin
         wb(1'b0, REQ_CMD_OFS, 32'h0000_0000);
         i++;
      end
      while (rdat[CMD_BUSY_BIT] !== 1'b0 && i < 50);
      if (i >= 50)
      begin
         failures++;
         close_out();
      end
      if (n >= 0)
         chk("strobe cycles", 32'((n + 1 > int'(l)) ? n + 2 : int'(l) + 1), 32'(len));
      chk("bus controls", {26'h0, sp == EWC_SP_PROG, sp == EWC_SP_DATA, sp == EWC_SP_IO, !w, !w, 1'b1},
          {26'h0, cap});
      chk("ext address", {16'h0, a}, {16'h0, cap_addr});
      chk("write enable", {31'h0, w}, {31'h0, cap_oe});
      if (w)
         chk("write data", {16'h0, d}, {16'h0, cap_dout});
      else
      begin
         wb(1'b0, REQ_DATA_OFS, 32'h0000_0000);
         chk("read data", {16'h0, d}, {16'h0, rdat[15:0]});
      end
   endtask : acc
   task automatic t_regs;
      wb(1'b0, WAIT_CTRL_OFS, 32'h0000_0000);
      chk("wait ctrl reset", {16'h0, WAIT_CTRL_RST}, rdat);
      chk("idle controls", 32'h0000_0002, {26'h0, ctl});
      wb(1'b1, WAIT_CTRL_OFS, 32'h0000_0a21);
      wb(1'b0, WAIT_CTRL_OFS, 32'h0000_0000);
      chk("wait ctrl", 32'h0000_0a21, rdat);
   endtask : t_regs
   task automatic t_prog;
      acc(EWC_SP_PROG, 1'b1, 16'h8005, 16'ha5c3, 4, 4'h0);
      acc(EWC_SP_PROG, 1'b0, 16'h8005, 16'ha5c3, 4, 4'h0);
      acc(EWC_SP_PROG, 1'b1, 16'h7f10, 16'h3c5a, 1, 4'h0);
      acc(EWC_SP_PROG, 1'b0, 16'h7f10, 16'h3c5a, 1, 4'h6);
   endtask : t_prog
   task automatic t_io_data;
      acc(EWC_SP_IO, 1'b1, 16'h0012, 16'h1234, 5, 4'h3);
      acc(EWC_SP_IO, 1'b0, 16'h0012, 16'h1234, 5, 4'h0);
      acc(EWC_SP_DATA, 1'b1, 16'h0033, 16'hbeef, 0, 4'h0);
      acc(EWC_SP_DATA, 1'b0, 16'h0033, 16'hbeef, 0, 4'h2);
   endtask : t_io_data
   task automatic t_zero;
      wb(1'b1, WAIT_CTRL_OFS, 32'h0000_0000);
      acc(EWC_SP_PROG, 1'b0, 16'h8005, 16'ha5c3, 0, 4'h0);
      acc(EWC_SP_IO, 1'b0, 16'h0012, 16'h1234, 0, 4'h5);
   endtask : t_zero
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_prog();
      t_io_data();
      t_zero();
      close_out();
   end
endmodule : ewc_top_tb
`default_nettype wire
